// [rtl/access_partition_pkg.sv]
package access_partition_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int SEG_NUM = 64;
  localparam int SEG_IDX_W = 6;
  localparam int HWC_NUM = 16;
  localparam int HWC_W = 4;

  // Physical partition boundaries (ROM, NVM, RAM windows).
  localparam logic [ADDR_W-1:0] ROM_BASE = 24'h000000;
  localparam logic [ADDR_W-1:0] ROM_TEST_END = 24'h007FFF;
  localparam logic [ADDR_W-1:0] ROM_END = 24'h03FFFF;
  localparam logic [ADDR_W-1:0] NVM_BASE = 24'h080000;
  localparam logic [ADDR_W-1:0] NVM_RSV_END = 24'h080FFF;
  localparam logic [ADDR_W-1:0] NVM_RSV_EMU_END = 24'h081FFF;
  localparam logic [ADDR_W-1:0] NVM_END = 24'h0A3FFF;
  localparam logic [ADDR_W-1:0] RAM_BASE = 24'h100000;
  localparam logic [ADDR_W-1:0] RAM_RSV_END = 24'h1003FF;
  localparam logic [ADDR_W-1:0] RAM_END = 24'h101FFF;

  // Segment table layout: table base plus index times entry size.
  localparam int SEG_ENTRY_BYTES_LOG2 = 4;

  // Register file selectors.
  localparam logic [3:0] REG_TBL_PTR = 4'h0;
  localparam logic [3:0] REG_FW_HWC = 4'h1;
  localparam logic [3:0] REG_FW_BASE = 4'h2;
  localparam logic [3:0] REG_FW_SIZE = 4'h3;
  localparam logic [3:0] REG_HW_COMP = 4'h4;
  localparam logic [ADDR_W-1:0] TBL_PTR_RST = 24'h100000;
  localparam logic [HWC_NUM-1:0] FW_HWC_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] FW_BASE_RST = 24'h000000;
  localparam logic [ADDR_W-1:0] FW_SIZE_RST = 24'h000000;

  localparam logic [1:0] ACC_READ = 2'h0;
  localparam logic [1:0] ACC_WRITE = 2'h1;
  localparam logic [1:0] ACC_EXEC = 2'h2;

  typedef enum logic [2:0] {
    MODE_BOOT = 3'b000,
    MODE_TEST = 3'b001,
    MODE_EMUL = 3'b010,
    MODE_SYS = 3'b011,
    MODE_USER = 3'b100
  } cpu_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_CHECK = 2'b10
  } xlate_state_type;

endpackage

// [rtl/segment_check.sv]
`timescale 1ns/1ps
module segment_check
  import access_partition_pkg::*;
(
  input wire logic [ADDR_W-1:0] vAddr,
  input wire logic [1:0] accType,
  input wire logic [2:0] segRights,
  input wire logic [ADDR_W-1:0] segFirst,
  input wire logic [ADDR_W-1:0] segLast,
  input wire logic [ADDR_W-1:0] segOffset,
  output logic hit,
  output logic [ADDR_W-1:0] physAddr
);

  logic inRange;
  logic rightOk;

  // A segment with no rights is disabled and never matches.
  always_comb begin
    inRange = (vAddr >= segFirst) && (vAddr <= segLast);
    case (accType)
      ACC_READ: rightOk = segRights[0];
      ACC_WRITE: rightOk = segRights[1];
      ACC_EXEC: rightOk = segRights[2];
      default: rightOk = 1'b0;
    endcase
    hit = inRange && rightOk && (segRights != 3'b000);
    physAddr = ADDR_W'(vAddr + segOffset);
  end

endmodule

// [rtl/cpu_mode_access_partition.sv]
`timescale 1ns/1ps
// What this block does
// - Five distinct CPU privilege modes separate vendor and application software.
// - Vendor and application software isolated by partitions and by modes.
// - Access rights and hardware configuration only writable from system and test modes.
// - User code reaches only memory granted by its own segment.
// - Hardware-component registers blocked in emulation and user modes unless explicitly granted.
// - Contact-only configuration suppresses every entry into emulation mode.
// - Suppressed vectored calls keep the mode and act as normal calls.
// - Contact-only: system mode reaches the whole RAM; user segments still exclude reserved RAM.
// - Contact-only: firewall registers stay read/write but have no effect.
// - Dual: firewall mask limits emulation-mode hardware register access.
// - Dual: firewall defines RAM exchange window for emulation code.
// - Reserved NVM size depends on emulation option; fixed when contact-only.
// - ROM split into test and application partitions, checked separately.
// - NVM and RAM split into reserved and application parts.
// - Table pointer register locates segment descriptors read by translation.
// - Segments may only map into application partitions.
// - Denied register read returns zero; denied write ignored.
// - Up to 64 segments with rights, bounds and offset; none disables.
// - Mode derived from program status high and two internal bits.
// - User-mode virtual addresses translated, and all addresses checked, before memory access.
module cpu_mode_access_partition
  import access_partition_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic dualSel,
  input wire logic emulEnable,
  input wire logic [1:0] programStatusHigh,
  input wire logic [1:0] internalBits,
  input wire logic callVectorEntry,
  output logic [2:0] cpuMode,
  output logic dualActive,
  input wire logic memReq,
  input wire logic [1:0] memAccType,
  input wire logic [ADDR_W-1:0] memVAddr,
  input wire logic [SEG_IDX_W-1:0] segIndex,
  output logic memGrant,
  output logic memDeny,
  output logic [ADDR_W-1:0] memPAddr,
  output logic tblReq,
  output logic [ADDR_W-1:0] tblAddr,
  input wire logic tblValid,
  input wire logic [2:0] tblRights,
  input wire logic [ADDR_W-1:0] tblFirst,
  input wire logic [ADDR_W-1:0] tblLast,
  input wire logic [ADDR_W-1:0] tblOffset,
  input wire logic [HWC_NUM-1:0] tblHwcGrant,
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [3:0] regSel,
  input wire logic [HWC_W-1:0] regHwc,
  input wire logic [ADDR_W-1:0] regWData,
  input wire logic [ADDR_W-1:0] hwRData,
  output logic regDenied,
  output logic hwWriteEn,
  output logic [ADDR_W-1:0] regRData
);

  cpu_mode_type modeNow;
  logic cfgSampled_r;
  logic dual_r;
  logic [ADDR_W-1:0] tblPtr_r;
  logic [HWC_NUM-1:0] fwHwc_r;
  logic [ADDR_W-1:0] fwBase_r;
  logic [ADDR_W-1:0] fwSize_r;
  logic [HWC_NUM-1:0] userHwc_r;
  xlate_state_type state_r;
  xlate_state_type state_nxt;
  logic [2:0] segRights_r;
  logic [ADDR_W-1:0] segFirst_r;
  logic [ADDR_W-1:0] segLast_r;
  logic [ADDR_W-1:0] segOffset_r;
  logic segHit;
  logic [ADDR_W-1:0] segPhys;
  logic partOk;
  logic grantNxt;

  function automatic logic inSpan(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                  input logic [ADDR_W-1:0] hi);
    inSpan = (a >= lo) && (a <= hi);
  endfunction

  // Sampling once after reset keeps the option stable even if the strap pin glitches later.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgSampled_r <= 1'b0;
      dual_r <= 1'b0;
    end else if (!cfgSampled_r) begin
      cfgSampled_r <= 1'b1;
      dual_r <= dualSel;
    end
  end
  assign dualActive = dual_r;

  // Mode decode; emulation is entered by a vectored call only when allowed.
  always_comb begin
    case ({internalBits, programStatusHigh})
      4'b1000, 4'b1001, 4'b1010, 4'b1011: modeNow = MODE_BOOT;
      4'b0100, 4'b0101, 4'b0110, 4'b0111: modeNow = MODE_TEST;
      4'b1100, 4'b1101, 4'b1110, 4'b1111: modeNow = MODE_EMUL;
      4'b0001: modeNow = MODE_SYS;
      default: modeNow = MODE_USER;
    endcase
    if (modeNow == MODE_EMUL && !(dual_r && emulEnable)) begin
      modeNow = MODE_SYS;
    end
    if (callVectorEntry && dual_r && emulEnable &&
        (modeNow == MODE_SYS || modeNow == MODE_USER)) begin
      modeNow = MODE_EMUL;
    end
  end
  assign cpuMode = modeNow;

  // Physical partition access per mode.
  always_comb begin
    logic inTestRom;
    logic inAppRom;
    logic inRsvNvm;
    logic inAppNvm;
    logic inRsvRam;
    logic inAppRam;
    logic [ADDR_W-1:0] nvmRsvEnd;
    logic inWin;
    nvmRsvEnd = (dual_r && emulEnable) ? NVM_RSV_EMU_END : NVM_RSV_END;
    inTestRom = inSpan(memVAddr, ROM_BASE, ROM_TEST_END);
    inAppRom = inSpan(memVAddr, ROM_TEST_END + 24'h000001, ROM_END);
    inRsvNvm = inSpan(memVAddr, NVM_BASE, nvmRsvEnd);
    inAppNvm = inSpan(memVAddr, nvmRsvEnd + 24'h000001, NVM_END);
    inRsvRam = dual_r && emulEnable && inSpan(memVAddr, RAM_BASE, RAM_RSV_END);
    inAppRam = inSpan(memVAddr, RAM_BASE, RAM_END) && !inRsvRam;
    // The exchange window only ever opens onto application RAM, never onto ROM, NVM or reserved RAM.
    inWin = dual_r && inAppRam && (fwSize_r != 24'h000000) &&
            inSpan(memVAddr, fwBase_r, ADDR_W'(fwBase_r + fwSize_r - 24'h000001));
    case (modeNow)
      MODE_TEST: partOk = inSpan(memVAddr, ROM_BASE, ROM_END) || inSpan(memVAddr, NVM_BASE, NVM_END) ||
                          inSpan(memVAddr, RAM_BASE, RAM_END);
      MODE_BOOT, MODE_EMUL: partOk = ((inTestRom && memAccType != ACC_WRITE) || inRsvNvm ||
                                      ((inRsvRam || (modeNow == MODE_EMUL && inWin)) && memAccType != ACC_EXEC));
      MODE_SYS: partOk = (inAppRom && memAccType != ACC_WRITE) || inAppNvm ||
                         (inAppRam && memAccType != ACC_EXEC);
      default: partOk = (inAppRom || inAppNvm || inAppRam);
    endcase
  end

  // Translation sequencer: user accesses fetch their descriptor first.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (memReq && modeNow == MODE_USER) state_nxt = ST_FETCH;
      ST_FETCH: if (tblValid) state_nxt = ST_CHECK;
      ST_CHECK: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      segRights_r <= 3'b000;
      segFirst_r <= '0;
      segLast_r <= '0;
      segOffset_r <= '0;
      userHwc_r <= '0;
    end else if (state_r == ST_FETCH && tblValid) begin
      segRights_r <= tblRights;
      segFirst_r <= tblFirst;
      segLast_r <= tblLast;
      segOffset_r <= tblOffset;
      userHwc_r <= tblHwcGrant;
    end
  end

  // The pointer is used as written, so software must keep it aligned to a whole descriptor.
  assign tblReq = (state_r == ST_FETCH);
  assign tblAddr = ADDR_W'(tblPtr_r + {segIndex, {SEG_ENTRY_BYTES_LOG2{1'b0}}});

  segment_check u_seg (
    .vAddr(memVAddr),
    .accType(memAccType),
    .segRights(segRights_r),
    .segFirst(segFirst_r),
    .segLast(segLast_r),
    .segOffset(segOffset_r),
    .hit(segHit),
    .physAddr(segPhys)
  );

  // Privileged modes resolve in one cycle; user mode only after the check state.
  always_comb begin
    logic [ADDR_W-1:0] pa;
    logic userOk;
    pa = segPhys;
    userOk = 1'b0;
    if (state_r == ST_CHECK) begin
      userOk = segHit && (inSpan(pa, ROM_TEST_END + 24'h000001, ROM_END) ||
               inSpan(pa, NVM_RSV_EMU_END + 24'h000001, NVM_END) ||
               inSpan(pa, RAM_RSV_END + 24'h000001, RAM_END));
    end
    grantNxt = (modeNow == MODE_USER) ? userOk : (memReq && partOk);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memGrant <= 1'b0;
      memDeny <= 1'b0;
      memPAddr <= '0;
    end else begin
      memGrant <= grantNxt;
      memDeny <= (modeNow == MODE_USER) ? (state_r == ST_CHECK && !grantNxt) : (memReq && !partOk);
      memPAddr <= (modeNow == MODE_USER) ? segPhys : memVAddr;
    end
  end

  // Register access control.
  logic regAllow;
  always_comb begin
    logic isCfg;
    isCfg = (regSel != REG_HW_COMP);
    case (modeNow)
      MODE_SYS, MODE_TEST, MODE_BOOT: regAllow = isCfg ? (modeNow != MODE_BOOT || !regWrite) : 1'b1;
      MODE_EMUL: regAllow = !isCfg && fwHwc_r[regHwc];
      default: regAllow = !isCfg && userHwc_r[regHwc];
    endcase
  end
  assign regDenied = regReq && !regAllow;
  assign hwWriteEn = regReq && regWrite && regAllow && (regSel == REG_HW_COMP);

  // Configuration registers written only from system and test modes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tblPtr_r <= TBL_PTR_RST;
      fwHwc_r <= FW_HWC_RST;
      fwBase_r <= FW_BASE_RST;
      fwSize_r <= FW_SIZE_RST;
    end else if (regReq && regWrite && regAllow) begin
      case (regSel)
        REG_TBL_PTR: tblPtr_r <= regWData;
        REG_FW_HWC: fwHwc_r <= regWData[HWC_NUM-1:0];
        REG_FW_BASE: fwBase_r <= regWData;
        REG_FW_SIZE: fwSize_r <= regWData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRData <= '0;
    end else if (regReq && !regWrite) begin
      if (!regAllow) begin
        regRData <= '0;
      end else begin
        case (regSel)
          REG_TBL_PTR: regRData <= tblPtr_r;
          REG_FW_HWC: regRData <= {{(ADDR_W-HWC_NUM){1'b0}}, fwHwc_r};
          REG_FW_BASE: regRData <= fwBase_r;
          REG_FW_SIZE: regRData <= fwSize_r;
          REG_HW_COMP: regRData <= hwRData;
          default: regRData <= '0;
        endcase
      end
    end
  end

  // These checks guard the access rules while the block runs.
  contactNoEmul_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cfgSampled_r && !dual_r) |-> cpuMode != MODE_EMUL) else $error("emulation mode in contact-only");
  deniedReadZero_a: assert property (@(posedge clk) disable iff (!arst_n)
    (regReq && !regWrite && !regAllow) |=> regRData == '0) else $error("denied read not zero");
  deniedWriteIgnored_a: assert property (@(posedge clk) disable iff (!arst_n)
    (regReq && regWrite && !regAllow) |=> $stable(tblPtr_r) && $stable(fwHwc_r) && $stable(fwBase_r) &&
    $stable(fwSize_r)) else $error("denied write took");
  userNoHwc_a: assert property (@(posedge clk) disable iff (!arst_n)
    (regReq && modeNow == MODE_USER && !userHwc_r[regHwc]) |-> !hwWriteEn) else $error("ungranted hw write");
  cfgHeld_a: assert property (@(posedge clk) disable iff (!arst_n)
    cfgSampled_r |=> $stable(dual_r)) else $error("config changed");
  sequence fetchDone_s;
    state_r == ST_FETCH && tblValid;
  endsequence
  userCheck_a: assert property (@(posedge clk) disable iff (!arst_n)
    fetchDone_s |=> state_r == ST_CHECK ##1 (memGrant || memDeny)) else $error("user check missing");
  tableAddr_a: assert property (@(posedge clk) disable iff (!arst_n)
    tblReq |-> tblAddr[SEG_ENTRY_BYTES_LOG2-1:0] == '0) else $error("table address misaligned");
  emptySeg_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == ST_CHECK && segRights_r == 3'b000) |=> !memGrant) else $error("disabled segment granted");
  contactRamOpen_a: assert property (@(posedge clk) disable iff (!arst_n)
    (memReq && cfgSampled_r && !dual_r && modeNow == MODE_SYS && memAccType != ACC_EXEC &&
     inSpan(memVAddr, RAM_BASE, RAM_END)) |=> memGrant) else $error("contact-only RAM blocked");
  emulHwMask_a: assert property (@(posedge clk) disable iff (!arst_n)
    (regReq && modeNow == MODE_EMUL && !fwHwc_r[regHwc]) |-> regDenied) else $error("firewall mask bypassed");
  cfgWriteSys_a: assert property (@(posedge clk) disable iff (!arst_n)
    (regReq && regWrite && regSel != REG_HW_COMP && modeNow != MODE_SYS && modeNow != MODE_TEST) |-> regDenied)
    else $error("configuration write outside system mode");
  userGrantApp_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_r == ST_CHECK && modeNow == MODE_USER && grantNxt) |=> !inSpan(memPAddr, ROM_BASE, ROM_TEST_END) &&
    !inSpan(memPAddr, NVM_BASE, NVM_RSV_EMU_END) && !inSpan(memPAddr, RAM_BASE, RAM_RSV_END))
    else $error("segment outside application partition");

endmodule

// [tb/seg_table_model.sv]
`timescale 1ns/1ps
module seg_table_model
  import access_partition_pkg::*;
#(
  parameter logic [ADDR_W-1:0] SEG_LAST = 24'h00FFFF,
  parameter logic [ADDR_W-1:0] SEG_OFFSET = 24'h090000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tblReq,
  input wire logic [ADDR_W-1:0] tblAddr,
  input wire logic [3:0] delay,
  input wire logic [2:0] cfgRights,
  output logic tblValid,
  output logic [2:0] tblRights,
  output logic [ADDR_W-1:0] tblFirst,
  output logic [ADDR_W-1:0] tblLast,
  output logic [ADDR_W-1:0] tblOffset,
  output logic [HWC_NUM-1:0] tblHwcGrant,
  output logic [ADDR_W-1:0] seenAddr
);
  logic [3:0] waitCnt;
  // Outside the valid beat the descriptor lines carry all ones after reset and the inverted descriptor after a beat, so early sampling shows up.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitCnt <= 4'h0;
      tblValid <= 1'b0;
      {tblRights, tblFirst, tblLast, tblOffset, tblHwcGrant} <= '1;
      seenAddr <= '0;
    end else if (tblValid) begin
      tblValid <= 1'b0;
      waitCnt <= 4'h0;
      {tblRights, tblFirst, tblLast, tblOffset, tblHwcGrant} <= ~{cfgRights, 24'h000000, SEG_LAST, SEG_OFFSET, 16'h0008};
    end else if (tblReq && waitCnt == delay) begin
      tblValid <= 1'b1;
      {tblRights, tblFirst, tblLast, tblOffset, tblHwcGrant} <= {cfgRights, 24'h000000, SEG_LAST, SEG_OFFSET, 16'h0008};
      seenAddr <= tblAddr;
    end else if (tblReq) begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import access_partition_pkg::*;
  localparam logic [ADDR_W-1:0] SEG_LAST = 24'h00FFFF;
  localparam logic [ADDR_W-1:0] SEG_OFFSET = 24'h090000;
  logic clk, arst_n, dualSel, emulEnable, callVectorEntry, memReq, regReq, regWrite, dualExp;
  logic dualActive, memGrant, memDeny, tblReq, tblValid, regDenied, hwWriteEn;
  logic [1:0] programStatusHigh, internalBits, memAccType;
  logic [2:0] cpuMode, tblRights, rightsCfg;
  logic [3:0] regSel, tblDelay;
  logic [HWC_W-1:0] regHwc;
  logic [SEG_IDX_W-1:0] segIndex;
  logic [HWC_NUM-1:0] tblHwcGrant;
  logic [HWC_NUM-1:0] userHwc;
  logic [ADDR_W-1:0] memVAddr, memPAddr, tblAddr, tblFirst, tblLast, tblOffset, seenAddr;
  logic [ADDR_W-1:0] regWData, hwRData, regRData;
  logic [ADDR_W-1:0] regModel [4];
  logic [ADDR_W-1:0] addrs [8];
  logic [31:0] seed = 32'h77FF;
  cpu_mode_type curMode;
  int fail_count = 0;
  int samples_checked = 0;

  cpu_mode_access_partition dut_u (.clk, .arst_n, .dualSel, .emulEnable, .programStatusHigh, .internalBits,
    .callVectorEntry, .cpuMode, .dualActive, .memReq, .memAccType, .memVAddr, .segIndex, .memGrant, .memDeny,
    .memPAddr, .tblReq, .tblAddr, .tblValid, .tblRights, .tblFirst, .tblLast, .tblOffset, .tblHwcGrant,
    .regReq, .regWrite, .regSel, .regHwc, .regWData, .hwRData, .regDenied, .hwWriteEn, .regRData);
  seg_table_model #(.SEG_LAST(SEG_LAST), .SEG_OFFSET(SEG_OFFSET)) table_u (.clk, .arst_n, .tblReq, .tblAddr,
    .delay(tblDelay), .cfgRights(rightsCfg), .tblValid, .tblRights, .tblFirst, .tblLast, .tblOffset,
    .tblHwcGrant, .seenAddr);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [23:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[23:0];
  endfunction
  function automatic logic inR(input logic [ADDR_W-1:0] v, lo, hi);
    return v >= lo && v <= hi;
  endfunction
  function automatic cpu_mode_type decode(input logic [3:0] c);
    case (c[3:2])
      2'h2: return MODE_BOOT;
      2'h1: return MODE_TEST;
      2'h3: return (dualExp && emulEnable) ? MODE_EMUL : MODE_SYS;
      default: return (c == 4'h1) ? MODE_SYS : MODE_USER;
    endcase
  endfunction
  function automatic logic expGrant(input cpu_mode_type m, input logic [1:0] a, input logic [ADDR_W-1:0] v);
    logic rx, rw, rNvm, rRam, aRam, win;
    rx = a != ACC_WRITE;
    rw = a != ACC_EXEC;
    rNvm = inR(v, NVM_BASE, (dualExp && emulEnable) ? NVM_RSV_EMU_END : NVM_RSV_END);
    rRam = dualExp && emulEnable && inR(v, RAM_BASE, RAM_RSV_END);
    aRam = inR(v, RAM_BASE, RAM_END) && !rRam;
    win = dualExp && aRam && v >= regModel[2] && v - regModel[2] < regModel[3];
    case (m)
      MODE_BOOT, MODE_EMUL: return (rx && inR(v, ROM_BASE, ROM_TEST_END)) || rNvm || (rw && (rRam || (m == MODE_EMUL && win)));
      MODE_TEST: return inR(v, ROM_BASE, ROM_END) || inR(v, NVM_BASE, NVM_END) || inR(v, RAM_BASE, RAM_END);
      MODE_SYS: return (rx && inR(v, ROM_TEST_END + 1, ROM_END)) || (!rNvm && inR(v, NVM_BASE, NVM_END)) || (rw && aRam);
      default: return v <= SEG_LAST && rightsCfg[a] && v + SEG_OFFSET <= NVM_END;
    endcase
  endfunction

  task automatic conclude();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic doReset(input logic d);
    @(posedge clk);
    arst_n <= 1'b0;
    dualSel <= d;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Flipping the select after release shows that only the first edge counts.
    dualSel <= !d;
    dualExp = d;
    regModel = '{TBL_PTR_RST, ADDR_W'(FW_HWC_RST), FW_BASE_RST, FW_SIZE_RST};
    userHwc = '0;
    @(posedge clk);
    #1;
    chk(dualActive === d, "configuration latch");
  endtask
  task automatic setMode(input logic [3:0] c);
    @(posedge clk);
    {internalBits, programStatusHigh} <= c;
    curMode = decode(c);
    #1;
    chk(cpuMode === curMode, "mode decode");
  endtask
  task automatic callCheck(input logic [3:0] c);
    setMode(c);
    @(posedge clk);
    callVectorEntry <= 1'b1;
    #1;
    chk(cpuMode === ((dualExp && emulEnable) ? MODE_EMUL : curMode), "vectored call");
    @(posedge clk);
    callVectorEntry <= 1'b0;
  endtask
  task automatic memOp(input logic [1:0] a, input logic [ADDR_W-1:0] v);
    logic g;
    logic got;
    g = expGrant(curMode, a, v);
    got = 1'b0;
    @(posedge clk);
    memReq <= 1'b1;
    memAccType <= a;
    memVAddr <= v;
    segIndex <= SEG_IDX_W'(rnd());
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge clk);
      if (curMode != MODE_USER) memReq <= 1'b0;
      #1;
      got = (memGrant === 1'b1) || (memDeny === 1'b1);
    end
    memReq <= 1'b0;
    if (!got) begin
      chk(1'b0, "memory answer missing");
      conclude();
    end
    chk(memGrant === g && memDeny === !g, "memory verdict");
    if (curMode != MODE_USER) chk(memPAddr === v, "untranslated address");
    if (curMode == MODE_USER && g) chk(memPAddr === v + SEG_OFFSET, "relocation");
    if (curMode == MODE_USER) chk(seenAddr === regModel[0] + (ADDR_W'(segIndex) << 4), "descriptor address");
    if (curMode == MODE_USER) userHwc = 16'h0008;
  endtask
  task automatic regOp(input logic w, input logic [3:0] s, input logic [HWC_W-1:0] h, input logic [ADDR_W-1:0] d);
    logic den;
    logic [ADDR_W-1:0] rdExp;
    den = (s < 4'h4) ? (!(curMode == MODE_SYS || curMode == MODE_TEST) && (w || curMode != MODE_BOOT)) :
          ((curMode == MODE_EMUL && !regModel[1][h]) || (curMode == MODE_USER && !userHwc[h]));
    rdExp = den ? '0 : ((s == 4'h4) ? d : regModel[s[1:0]]);
    @(posedge clk);
    {regReq, regWrite, regSel, regHwc, regWData, hwRData} <= {1'b1, w, s, h, d, d};
    #1;
    chk(regDenied === den, "register permission");
    chk(hwWriteEn === (w && s == 4'h4 && !den), "component write strobe");
    @(posedge clk);
    regReq <= 1'b0;
    #1;
    if (!w) chk(regRData === rdExp, "register read");
    if (w && !den && s < 4'h4) regModel[s[1:0]] = (s == 4'h1) ? (d & 24'h00FFFF) : d;
  endtask
  task automatic sweep(input logic [3:0] c);
    setMode(c);
    addrs = '{24'h000100, 24'h010000, 24'h080100, 24'h081800, 24'h090000 | (rnd() & 24'h00FFFF), 24'h100100,
              24'h101000, 24'h101800};
    foreach (addrs[i]) for (int a = 0; a < 3; a++) memOp(a[1:0], addrs[i]);
  endtask

  initial begin
    {arst_n, dualSel, callVectorEntry, memReq, regReq, regWrite, programStatusHigh, internalBits} = '0;
    {memAccType, regSel, regHwc, segIndex, memVAddr, regWData, hwRData, rightsCfg, tblDelay} = '0;
    emulEnable = 1'b1;
    doReset(1'b1);
    for (int i = 0; i < 16; i++) setMode(i[3:0]);
    callCheck(4'h1);
    callCheck(4'h0);
    setMode(4'h1);
    for (int s = 0; s < 4; s++) regOp(1'b0, s[3:0], 4'h0, 24'h0);
    regOp(1'b1, 4'h0, 4'h0, 24'h100200);
    regOp(1'b1, 4'h1, 4'h0, 24'h000008);
    regOp(1'b1, 4'h2, 4'h0, 24'h101000);
    regOp(1'b1, 4'h3, 4'h0, 24'h000100);
    regOp(1'b1, 4'h4, 4'h2, rnd());
    regOp(1'b0, 4'h4, 4'h2, rnd());
    setMode(4'h0);
    regOp(1'b1, 4'h0, 4'h0, 24'h100300);
    setMode(4'h8);
    regOp(1'b1, 4'h1, 4'h0, 24'h00FFFF);
    regOp(1'b0, 4'h1, 4'h0, 24'h0);
    for (int i = 0; i < 4; i++) sweep(i == 0 ? 4'h8 : (i == 1 ? 4'h4 : (i == 2 ? 4'hC : 4'h1)));
    setMode(4'hC);
    regOp(1'b1, 4'h4, 4'h3, rnd());
    regOp(1'b1, 4'h4, 4'h5, rnd());
    regOp(1'b0, 4'h4, 4'h5, rnd());
    setMode(4'h0);
    for (int k = 0; k < 6; k++) begin
      rightsCfg = (k < 2) ? 3'h0 : ((k < 4) ? 3'h1 : 3'h7);
      tblDelay = k[0] ? 4'h5 : 4'h0;
      for (int a = 0; a < 3; a++) memOp(a[1:0], rnd() & SEG_LAST);
    end
    memOp(ACC_READ, SEG_LAST);
    memOp(ACC_READ, SEG_LAST + 24'h1);
    regOp(1'b1, 4'h4, 4'h3, rnd());
    regOp(1'b0, 4'h4, 4'h1, rnd());
    regOp(1'b0, 4'h0, 4'h0, 24'h0);
    doReset(1'b0);
    callCheck(4'h1);
    callCheck(4'h0);
    setMode(4'hC);
    setMode(4'h1);
    regOp(1'b1, 4'h2, 4'h0, 24'h100100);
    regOp(1'b1, 4'h3, 4'h0, 24'h000200);
    regOp(1'b0, 4'h2, 4'h0, 24'h0);
    sweep(4'h1);
    sweep(4'h4);
    emulEnable <= 1'b0;
    doReset(1'b1);
    callCheck(4'h1);
    setMode(4'hC);
    sweep(4'h1);
    sweep(4'h8);
    conclude();
  end
endmodule
